// ===== cmal_core.sv
// Operating mode and address generation core of the CPU.
// Assumes a word-wide internal bus that answers each request with an ack.
//
// Contract
// [RULE1] Normal mode uses 16-bit effective addresses only.
// [RULE2] Normal vectors: 16-bit entries from address zero.
// [RULE3] Normal indirect: 16-bit word in low 256 bytes.
// [RULE4] Advanced vectors: 32-bit entries, low 24 bits used.
// [RULE5] Advanced indirect: longword, upper byte read as zero.
// [RULE6] Calls push PC; exceptions push PC and flags.
// [RULE7] Normal post-increment carry reaches the upper half.
// [RULE8] Advanced mode: 16-Mbyte linear, full register addresses.
// [RULE9] Mode comes from mode pins, not software.
// [RULE10] Multiply takes 12, 20, 13, 21 states.
// [RULE11] Simple operations finish in one state.
// [RULE12] Registers viewed as 16x16, 16x8 or 8x32.
// [RULE13] Sleep enters power-down; clock speed selectable.
// [RULE14] Reset loads PC from vector, sets mask, clears trace.
// [RULE15] Odd word addresses have bit zero forced low; the INC/DEC EA on O_EA keeps bit zero.
// [RULE16] Mode captured at reset, constant while running.
`timescale 1ns/1ps
`default_nettype none

module cmal_core
   import cmal_pkg::*;
(
   input  wire logic        I_CLK_SYS,
   input  wire logic        I_RESET_N,
   input  wire logic        I_MODE_ADV,
   input  wire logic        I_REQ,
   input  wire logic [3:0]  I_CMD,
   input  wire logic [31:0] I_ADDR,
   input  wire logic [1:0]  I_SIZE,
   input  wire logic        I_UPPER,
   input  wire logic [23:0] I_PC,
   input  wire logic [7:0]  I_CCR,
   input  wire logic        I_MUL_SIGNED,
   input  wire logic [15:0] I_MUL_A,
   input  wire logic [15:0] I_MUL_B,
   input  wire logic        I_WAKE,
   input  wire logic [1:0]  I_CLK_SEL,
   input  wire logic        I_MEM_ACK,
   input  wire logic [15:0] I_MEM_RDATA,
   output logic             O_MODE_ADV,
   output logic             O_BUSY,
   output logic             O_DONE,
   output logic [31:0]      O_RESULT,
   output logic [23:0]      O_EA,
   output logic [23:0]      O_PC,
   output logic             O_INTMASK,
   output logic             O_TRACE,
   output logic             O_SLEEP,
   output logic [1:0]       O_CLK_SEL,
   output logic             O_MEM_REQ,
   output logic             O_MEM_WR,
   output logic [23:0]      O_MEM_ADDR,
   output logic [15:0]      O_MEM_WDATA
);
   typedef enum logic [2:0] {ST_BOOT, ST_IDLE, ST_MEM, ST_MUL, ST_SLEEP}
      cmal_state_t;

   cmal_state_t state;
   cmal_cmd_t   cmd;
   cmal_cmd_t   cur_cmd;
   logic        take;
   logic        mul_start;
   logic        mul_done;
   logic [31:0] mul_product;
   logic        seq_two;
   logic        seq_idx;
   logic        seq_boot;
   logic [23:0] seq_a1;
   logic [15:0] seq_d1;
   logic [15:0] rd_hi;
   logic [31:0] new_sp;
   logic [31:0] step_reg;

   // Keeps only the address bits the active mode can reach.
   function automatic logic [23:0] mode_addr(input logic adv,
                                             input logic [31:0] a);
      mode_addr = adv ? a[ADV_ADDR_W-1:0]
                      : {8'h00, a[NORM_ADDR_W-1:0]}; // [RULE1] [RULE8]
   endfunction

   // Word and longword accesses never fault; except the INC/DEC EA, they drop to the even byte.
   function automatic logic [23:0] align(input logic [23:0] a);
      align = {a[23:1], 1'b0}; // [RULE15]
   endfunction

   function automatic logic [31:0] step_of(input logic [1:0] sz);
      step_of = (sz == SZ_BYTE) ? 32'h1 : (sz == SZ_WORD) ? 32'h2 : 32'h4;
   endfunction

   // Word views pick the low or high half of a full register; byte views pick the low or high byte of its low word.
   function automatic logic [31:0] view(input logic [1:0] sz,
                                        input logic up,
                                        input logic [31:0] v);
      if (sz == SZ_BYTE)
         view = {24'h000000, up ? v[15:8] : v[7:0]}; // [RULE12]
      else if (sz == SZ_WORD)
         view = {16'h0000, up ? v[31:16] : v[15:0]}; // [RULE12]
      else
         view = v; // [RULE12]
   endfunction

   assign cmd       = cmal_cmd_t'(I_CMD);
   assign take      = I_REQ && (state == ST_IDLE);
   assign mul_start = take && (cmd == CMD_MUL);
   assign step_reg  = (cmd == CMD_INC) ? I_ADDR + step_of(I_SIZE)
                                       : I_ADDR - step_of(I_SIZE); // [RULE7]
   assign new_sp    = I_ADDR - ((O_MODE_ADV || cmd == CMD_EXC) ? 32'h4
                                                               : 32'h2);

   cmal_mul u_mul (
      .i_clk     (I_CLK_SYS),
      .i_reset_n (I_RESET_N),
      .i_start   (mul_start),
      .i_signed  (I_MUL_SIGNED),
      .i_word    (I_SIZE != SZ_BYTE),
      .i_a       (I_MUL_A),
      .i_b       (I_MUL_B),
      .o_done    (mul_done),
      .o_product (mul_product)
   );

   // The strap is caught by the first clock after release; a flop under
   // asynchronous reset may not load a pin.
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
         O_MODE_ADV <= 1'b0;
      else if (state == ST_BOOT && !O_MEM_REQ)
         O_MODE_ADV <= I_MODE_ADV; // [RULE9] [RULE16]
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         O_INTMASK <= INTMASK_RST; // [RULE14]
         O_TRACE   <= TRACE_RST;   // [RULE14]
         O_CLK_SEL <= 2'h0;
      end
      else
      begin
         if (take && cmd == CMD_EXC)
            O_INTMASK <= 1'b1;
         if (state == ST_IDLE)
            O_CLK_SEL <= I_CLK_SEL; // [RULE13]
      end
   end

   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         state       <= ST_BOOT;
         cur_cmd     <= CMD_VEC;
         O_BUSY      <= 1'b1;
         O_DONE      <= 1'b0;
         O_RESULT    <= 32'h00000000;
         O_EA        <= 24'h000000;
         O_PC        <= 24'h000000;
         O_SLEEP     <= 1'b0;
         O_MEM_REQ   <= 1'b0;
         O_MEM_WR    <= 1'b0;
         O_MEM_ADDR  <= 24'h000000;
         O_MEM_WDATA <= 16'h0000;
         seq_two     <= 1'b0;
         seq_idx     <= 1'b0;
         seq_boot    <= 1'b0;
         seq_a1      <= 24'h000000;
         seq_d1      <= 16'h0000;
         rd_hi       <= 16'h0000;
      end
      else
      begin
         O_DONE <= 1'b0;
         unique case (state)
            ST_BOOT:
            begin
               if (!O_MEM_REQ)
               begin
                  // Reset vector: word 0 in normal, longword 0 in advanced.
                  O_MEM_REQ  <= 1'b1; // [RULE14]
                  O_MEM_WR   <= 1'b0;
                  O_MEM_ADDR <= VEC_BASE + 24'(RESET_VEC_NUM);
                  seq_a1     <= VEC_BASE + 24'h2;
                  seq_two    <= I_MODE_ADV;
                  seq_idx    <= 1'b0;
                  seq_boot   <= 1'b1;
                  cur_cmd    <= CMD_VEC;
                  state      <= ST_MEM;
               end
            end
            ST_IDLE:
            begin
               if (take)
               begin
                  cur_cmd <= cmd;
                  O_BUSY  <= 1'b1;
                  unique case (cmd)
                     CMD_EA:
                     begin
                        O_EA <= (I_SIZE == SZ_BYTE)
                           ? mode_addr(O_MODE_ADV, I_ADDR)
                           : align(mode_addr(O_MODE_ADV, I_ADDR));
                        O_RESULT <= {8'h00, mode_addr(O_MODE_ADV, I_ADDR)};
                        O_DONE   <= 1'b1; // [RULE11]
                        O_BUSY   <= 1'b0;
                     end
                     CMD_INC, CMD_DEC:
                     begin
                        // The full register moves; only the address view is
                        // cut to the mode width.
                        O_RESULT <= step_reg; // [RULE7]
                        O_EA <= mode_addr(O_MODE_ADV,
                           (cmd == CMD_INC) ? I_ADDR : step_reg); // [RULE8]
                        O_DONE   <= 1'b1; // [RULE11]
                        O_BUSY   <= 1'b0;
                     end
                     CMD_VIEW:
                     begin
                        O_RESULT <= view(I_SIZE, I_UPPER, I_ADDR);
                        O_DONE   <= 1'b1; // [RULE11]
                        O_BUSY   <= 1'b0;
                     end
                     CMD_VEC, CMD_IND:
                     begin
                        // The vector number indexes a table of word or longword entries
                        // from zero; the indirect field is an even byte address in the low page.
                        O_MEM_REQ <= 1'b1;
                        O_MEM_WR  <= 1'b0;
                        seq_two   <= O_MODE_ADV;
                        seq_idx   <= 1'b0;
                        seq_boot  <= 1'b0;
                        if (cmd == CMD_IND)
                           O_MEM_ADDR <= align({16'h0000, I_ADDR[7:0]});
                        else if (O_MODE_ADV)
                           O_MEM_ADDR <= VEC_BASE
                              + {14'h0000, I_ADDR[7:0], 2'b00}; // [RULE4]
                        else
                           O_MEM_ADDR <= VEC_BASE
                              + {15'h0000, I_ADDR[7:0], 1'b0}; // [RULE2]
                        if (cmd == CMD_IND)
                           seq_a1 <= align({16'h0000, I_ADDR[7:0]})
                              + 24'h2; // [RULE3] [RULE5]
                        else
                           seq_a1 <= VEC_BASE
                              + {14'h0000, I_ADDR[7:0], 2'b10};
                        state <= ST_MEM;
                     end
                     CMD_CALL, CMD_EXC:
                     begin
                        // Only PC and the flags go to the stack; the extended
                        // control register has no place in the frame.
                        O_MEM_REQ   <= 1'b1; // [RULE6]
                        O_MEM_WR    <= 1'b1;
                        O_MEM_ADDR  <= align(mode_addr(O_MODE_ADV,
                                       I_ADDR - 32'h2));
                        O_MEM_WDATA <= I_PC[15:0];
                        seq_a1      <= align(mode_addr(O_MODE_ADV,
                                       I_ADDR - 32'h4));
                        seq_d1      <= O_MODE_ADV
                           ? {(cmd == CMD_EXC) ? I_CCR : RSV_UPPER,
                              I_PC[23:16]}
                           : {I_CCR, I_CCR}; // [RULE6]
                        seq_two     <= O_MODE_ADV || (cmd == CMD_EXC);
                        seq_idx     <= 1'b0;
                        seq_boot    <= 1'b0;
                        O_RESULT    <= new_sp;
                        state       <= ST_MEM;
                     end
                     CMD_MUL:
                        state <= ST_MUL;
                     CMD_SLEEP:
                     begin
                        O_SLEEP <= 1'b1; // [RULE13]
                        O_DONE  <= 1'b1;
                        state   <= ST_SLEEP;
                     end
                     default:
                     begin
                        O_DONE <= 1'b1;
                        O_BUSY <= 1'b0;
                     end
                  endcase
               end
            end
            ST_MEM:
            begin
               if (I_MEM_ACK)
               begin
                  if (seq_two && !seq_idx)
                  begin
                     rd_hi       <= I_MEM_RDATA;
                     seq_idx     <= 1'b1;
                     O_MEM_ADDR  <= seq_a1;
                     O_MEM_WDATA <= seq_d1;
                  end
                  else
                  begin
                     O_MEM_REQ <= 1'b0;
                     if (!O_MEM_WR)
                     begin
                        // Reserved upper byte of a longword entry reads zero.
                        O_RESULT <= seq_two
                           ? {RSV_UPPER, rd_hi[7:0], I_MEM_RDATA} // [RULE4]
                           : {16'h0000, I_MEM_RDATA}; // [RULE2] [RULE3]
                        if (seq_boot)
                           O_PC <= seq_two
                              ? {rd_hi[7:0], I_MEM_RDATA}
                              : {8'h00, I_MEM_RDATA}; // [RULE14]
                     end
                     O_DONE <= !seq_boot;
                     O_BUSY <= 1'b0;
                     state  <= ST_IDLE;
                  end
               end
            end
            ST_MUL:
            begin
               if (mul_done)
               begin
                  O_RESULT <= mul_product; // [RULE10]
                  O_DONE   <= 1'b1;
                  O_BUSY   <= 1'b0;
                  state    <= ST_IDLE;
               end
            end
            ST_SLEEP:
            begin
               if (I_WAKE)
               begin
                  O_SLEEP <= 1'b0;
                  O_BUSY  <= 1'b0;
                  state   <= ST_IDLE;
               end
            end
         endcase
      end
   end

   // Helper: states elapsed since a multiply was taken, and its due count.
   logic [4:0] mul_age;
   logic [4:0] mul_due;
   always_ff @(posedge I_CLK_SYS or negedge I_RESET_N)
   begin
      if (!I_RESET_N)
      begin
         mul_age <= 5'h00;
         mul_due <= 5'h00;
      end
      else if (mul_start)
      begin
         mul_age <= 5'h01;
         mul_due <= (I_SIZE != SZ_BYTE)
            ? (I_MUL_SIGNED ? MUL_WS_STATES : MUL_WU_STATES)
            : (I_MUL_SIGNED ? MUL_BS_STATES : MUL_BU_STATES);
      end
      else if (state == ST_MUL)
         mul_age <= mul_age + 5'h01;
   end

   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RESET_N);

   chk_norm_addr_width: assert property ( // [RULE1]
      (O_MEM_REQ && !O_MODE_ADV && state != ST_BOOT)
         |-> O_MEM_ADDR[23:16] == 8'h00)
      else $error("normal mode address above 64 kbytes");
   chk_norm_vec_area: assert property ( // [RULE2]
      (O_MEM_REQ && cur_cmd == CMD_VEC && !O_MODE_ADV)
         |-> O_MEM_ADDR[23:9] == 15'h0000)
      else $error("normal vector fetch outside table");
   chk_ind_low_page: assert property ( // [RULE3] [RULE5]
      (O_MEM_REQ && cur_cmd == CMD_IND) |-> O_MEM_ADDR[23:8] == 16'h0000)
      else $error("indirect fetch outside low page");
   chk_adv_upper_zero: assert property ( // [RULE4]
      (O_DONE && O_MODE_ADV && (cur_cmd == CMD_VEC || cur_cmd == CMD_IND))
         |-> O_RESULT[31:24] == RSV_UPPER)
      else $error("reserved upper byte not zero");
   chk_mode_held: assert property ( // [RULE16]
      (state != ST_BOOT && $past(state) != ST_BOOT) |-> $stable(O_MODE_ADV))
      else $error("mode changed while running");
   chk_mul_count: assert property ( // [RULE10]
      (O_DONE && cur_cmd == CMD_MUL) |-> mul_age == mul_due)
      else $error("multiply state count wrong");
   chk_simple_one: assert property ( // [RULE11]
      (take && (cmd == CMD_EA || cmd == CMD_INC || cmd == CMD_DEC))
         |=> O_DONE && !O_BUSY)
      else $error("simple operation not done in one state");
   chk_word_even: assert property ( // [RULE15]
      O_MEM_REQ |-> !O_MEM_ADDR[0])
      else $error("odd word address on bus");
   chk_call_frame: assert property ( // [RULE6]
      (take && cmd == CMD_CALL && !O_MODE_ADV)
         |=> O_MEM_WR && O_MEM_WDATA == $past(I_PC[15:0]) && !seq_two)
      else $error("call frame not a single PC word");
   chk_inc_carry: assert property ( // [RULE7]
      (take && cmd == CMD_INC && I_ADDR[15:0] == 16'hffff)
         |=> O_RESULT[31:16] == $past(I_ADDR[31:16]) + 16'h0001)
      else $error("increment carry lost");
   chk_sleep_entry: assert property ( // [RULE13]
      (take && cmd == CMD_SLEEP) |=> O_SLEEP ##1 (O_SLEEP || $past(I_WAKE)))
      else $error("sleep not entered");

   cov_mul_word_signed: cover property (
      mul_start && I_SIZE == SZ_WORD && I_MUL_SIGNED ##21 O_DONE);
   cov_adv_vector: cover property (
      O_DONE && O_MODE_ADV && cur_cmd == CMD_VEC);
   cov_exc_push: cover property (O_DONE && cur_cmd == CMD_EXC);
   cov_sleep_wake: cover property (O_SLEEP ##1 !O_SLEEP);
endmodule // cmal_core

`default_nettype wire

// ===== cmal_core_tb.sv
// Bench for the mode and address core against a behavioural model.
// Assumes the memory model on the bus; inputs change at falling edges.
`timescale 1ns/1ps
`default_nettype none

module cmal_core_tb
   import cmal_pkg::*;
;
   logic        clk, rst_n, mode, req, upper, msgn, wake, ack, mreq, mwr;
   logic        madv, busy, done, imask, trace, slp;
   logic [1:0]  size, csel, ocsel;
   logic [3:0]  cmd, stall;
   logic [7:0]  condition_code_reg;
   logic [15:0] ma, mb, rdata, wdata, p16;
   logic [23:0] pc, ea, opc, maddr;
   logic [31:0] addr, res, a, r, sp, mk, p;
   logic [4:0]  mlat [4] = '{MUL_BU_STATES, MUL_WU_STATES,
                             MUL_BS_STATES, MUL_WS_STATES};
   int          miscompares, samples_checked, lat, d;

   cmal_core uut (
      .I_CLK_SYS(clk), .I_RESET_N(rst_n), .I_MODE_ADV(mode), .I_REQ(req),
      .I_CMD(cmd), .I_ADDR(addr), .I_SIZE(size), .I_UPPER(upper),
      .I_PC(pc), .I_CCR(condition_code_reg), .I_MUL_SIGNED(msgn), .I_MUL_A(ma),
      .I_MUL_B(mb), .I_WAKE(wake), .I_CLK_SEL(csel), .I_MEM_ACK(ack),
      .I_MEM_RDATA(rdata), .O_MODE_ADV(madv), .O_BUSY(busy), .O_DONE(done),
      .O_RESULT(res), .O_EA(ea), .O_PC(opc), .O_INTMASK(imask),
      .O_TRACE(trace), .O_SLEEP(slp), .O_CLK_SEL(ocsel), .O_MEM_REQ(mreq),
      .O_MEM_WR(mwr), .O_MEM_ADDR(maddr), .O_MEM_WDATA(wdata));

   cmal_mem_model u_mem (.i_clk(clk), .i_req(mreq), .i_wr(mwr),
      .i_addr(maddr), .i_wdata(wdata), .i_stall(stall), .o_ack(ack),
      .o_rdata(rdata));

   initial
   begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   function automatic logic [15:0] rdm(input logic [23:0] x);
      rdm = x[15:0] ^ 16'h5a3c ^ {8'h00, x[23:16]};
   endfunction

   // Branch address fetch: one word in normal mode, two in advanced mode.
   function automatic logic [31:0] fetch(input logic adv,
                                         input logic [23:0] x);
      logic [15:0] w;
      w = rdm(x);
      fetch = adv ? {8'h00, w[7:0], rdm(x + 24'h2)} : {16'h0000, w};
   endfunction

   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (miscompares == 0 && samples_checked > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   task automatic opnd();
      @(negedge clk);
      a = $urandom;
      stall = 4'($urandom_range(3));
      pc = 24'($urandom);
      condition_code_reg = 8'($urandom);
      ma = 16'($urandom);
      mb = 16'($urandom);
      csel = 2'($urandom);
   endtask

   // Issues one command while idle and counts edges up to its done pulse.
   task automatic run(input logic [3:0] c, input logic [31:0] x,
                      input logic [1:0] s, input logic u);
      @(negedge clk);
      req = 1'b1;
      cmd = c;
      addr = x;
      size = s;
      upper = u;
      msgn = u;
      @(negedge clk);
      req = 1'b0;
      lat = 1;
      while (done !== 1'b1 && lat < 300)
      begin
         @(posedge clk);
         #1;
         lat++;
      end
      if (done !== 1'b1)
         miscompares++;
   endtask

   task automatic reset_to(input logic m);
      @(negedge clk);
      rst_n = 1'b0;
      mode = m;
      repeat (5) @(negedge clk);
      rst_n = 1'b1;
      lat = 0;
      while (busy !== 1'b0 && lat < 300)
      begin
         @(posedge clk);
         #1;
         lat++;
      end
      if (busy !== 1'b0)
         miscompares++;
      p = fetch(m, 24'h0);
      chk(opc, p[23:0]);
      chk(imask, 1'b1);
      chk(trace, 1'b0);
      @(negedge clk);
      mode = ~m;
   endtask

   // The span covers both modes with the slowest stalls several times over.
   initial
   begin
      #400000;
      miscompares++;
      give_verdict();
   end

   initial
   begin
      {rst_n, mode, req, upper, msgn, wake, size, csel, cmd, stall} = '0;
      {condition_code_reg, ma, mb, pc, addr} = '0;
      void'($urandom(54));
      for (int m = 0; m < 2; m++)
      begin
         reset_to(m[0]);
         mk = m ? 32'h00ffffff : 32'h0000ffff;
         for (int k = 0; k < 6; k++)
         begin
            opnd();
            d = $urandom_range(2);
            run(CMD_EA, a, 2'(d), 1'b0);
            chk(lat, 1);
            chk(ea, a & mk & ~{31'h0, d != 0});
            run(CMD_VEC, {24'h0, a[7:0]}, SZ_WORD, 1'b0);
            p = fetch(m[0], {14'h0, a[7:0], 2'h0} >> !m);
            chk(res, p);
            run(CMD_IND, {24'h0, a[15:8]}, SZ_WORD, 1'b0);
            p = fetch(m[0], {16'h0, a[15:9], 1'b0});
            chk(res, p);
            sp = (a & mk & 32'hfffffff0) | 32'h8;
            for (int e = 0; e < 2; e++)
            begin
               u_mem.wq.delete();
               run(e ? CMD_EXC : CMD_CALL, sp, SZ_LONG, 1'b0);
               d = (m == 0 && e == 0) ? 2 : 4;
               chk(res, sp - d);
               chk(u_mem.wq.size(), d / 2);
               chk(u_mem.wq[0], {(sp[23:0] - 24'h2) & mk[23:0],
                   pc[15:0]});
               if (d == 4)
                  chk(u_mem.wq[1], {(sp[23:0] - 24'h4) & mk[23:0],
                      m ? {e ? condition_code_reg : 8'h00, pc[23:16]} : {condition_code_reg, condition_code_reg}});
            end
            for (int s = 0; s < 3; s++)
            begin
               d = 1 << s;
               r = {a[31:16], 16'h0 - 16'(d)};
               run(CMD_INC, r, 2'(s), 1'b0);
               chk(res, 32'(r + d));
               chk(ea, r & mk);
               r = {a[31:16], 16'h0};
               run(CMD_DEC, r, 2'(s), 1'b0);
               chk(res, 32'(r - d));
               chk(ea, (r - d) & mk);
            end
            for (int v = 0; v < 5; v++)
            begin
               run(CMD_VIEW, a, 2'(v >> 1), v[0]);
               case (v)
                  0: p = {24'h0, a[7:0]};
                  1: p = {24'h0, a[15:8]};
                  2: p = {16'h0, a[15:0]};
                  3: p = {16'h0, a[31:16]};
                  default: p = a;
               endcase
               chk(res, p);
            end
            for (int q = 0; q < 4; q++)
            begin
               run(CMD_MUL, 32'h0, q[0] ? SZ_WORD : SZ_BYTE, q[1]);
               case (q)
                  0: p = ma[7:0] * mb[7:0];
                  1: p = ma * mb;
                  2: p16 = $signed(ma[7:0]) * $signed(mb[7:0]);
                  default: p = $signed(ma) * $signed(mb);
               endcase
               if (q == 2)
                  p = {16'h0, p16};
               chk(lat, mlat[q]);
               chk(res, p);
            end
         end
         run(4'ha, 32'h0, SZ_BYTE, 1'b0);
         chk(lat, 1);
         run(CMD_SLEEP, 32'h0, SZ_BYTE, 1'b0);
         chk(lat, 1);
         chk(slp, 1'b1);
         @(negedge clk);
         chk(busy, 1'b1);
         wake = 1'b1;
         @(posedge clk);
         #1;
         chk(slp, 1'b0);
         opnd();
         wake = 1'b0;
         repeat (2) @(posedge clk);
         #1;
         chk(ocsel, csel);
         chk(madv, m);
      end
      give_verdict();
   end
endmodule // cmal_core_tb
`default_nettype wire

// ===== cmal_mem_model.sv
// Memory model for the internal bus of the mode and address core.
// Assumes one clock; answers each bus word after a stall set by the bench.
`timescale 1ns/1ps
`default_nettype none

module cmal_mem_model
(
   input  wire logic        i_clk,
   input  wire logic        i_req,
   input  wire logic        i_wr,
   input  wire logic [23:0] i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic [3:0]  i_stall,
   output logic             o_ack,
   output logic [15:0]      o_rdata
);
   logic [3:0]  cnt;
   logic [39:0] wq[$];

   function automatic logic [15:0] rd(input logic [23:0] a);
      rd = a[15:0] ^ 16'h5a3c ^ {8'h00, a[23:16]};
   endfunction

   initial
   begin
      o_ack = 1'b0;
      o_rdata = 16'h1234;
      cnt = 4'h0;
   end

   // Read data toggles outside an answer, so a sample one state late never matches.
   always @(posedge i_clk)
   begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_req && !o_ack)
      begin
         if (cnt >= i_stall)
         begin
            o_ack <= 1'b1;
            cnt <= 4'h0;
            o_rdata <= rd(i_addr);
            if (i_wr)
               wq.push_back({i_addr, i_wdata});
         end
         else
            cnt <= cnt + 4'h1;
      end
   end
endmodule // cmal_mem_model
`default_nettype wire

// ===== cmal_mul.sv
// Package for the mode and address block, plus its multiply timer.
// Assumes one 125 MHz clock and an asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

package cmal_pkg;
   localparam int          NORM_ADDR_W   = 16;
   localparam int          ADV_ADDR_W    = 24;
   localparam logic [23:0] VEC_BASE      = 24'h000000;
   localparam logic [7:0]  RSV_UPPER     = 8'h00;
   localparam logic [4:0]  MUL_BU_STATES = 5'h0c;
   localparam logic [4:0]  MUL_WU_STATES = 5'h14;
   localparam logic [4:0]  MUL_BS_STATES = 5'h0d;
   localparam logic [4:0]  MUL_WS_STATES = 5'h15;
   localparam int          ADD_TIME_NS   = 50;
   localparam int          REF_CLK_MHZ   = 20;
   localparam int          ADD_STATES    = ADD_TIME_NS * REF_CLK_MHZ / 1000;
   localparam logic        INTMASK_RST   = 1'b1;
   localparam logic        TRACE_RST     = 1'b0;
   localparam logic [7:0]  RESET_VEC_NUM = 8'h00;
   localparam logic [1:0]  SZ_BYTE       = 2'h0;
   localparam logic [1:0]  SZ_WORD       = 2'h1;
   localparam logic [1:0]  SZ_LONG       = 2'h2;

   typedef enum logic [3:0] {
      CMD_EA, CMD_VEC, CMD_IND, CMD_CALL, CMD_EXC,
      CMD_INC, CMD_DEC, CMD_MUL, CMD_SLEEP, CMD_VIEW
   } cmal_cmd_t;
endpackage

module cmal_mul
   import cmal_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic        i_start,
   input  wire logic        i_signed,
   input  wire logic        i_word,
   input  wire logic [15:0] i_a,
   input  wire logic [15:0] i_b,
   output logic             o_done,
   output logic [31:0]      o_product
);
   logic [4:0] cnt;

   // Both this done flop and the caller's finish are registered, so the
   // count is loaded two states short of the full multiply time.
   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cnt    <= 5'h00;
         o_done <= 1'b0;
      end
      else
      begin
         o_done <= (cnt == 5'h01);
         if (i_start)
         begin
            unique case ({i_word, i_signed})
               2'b00: cnt <= MUL_BU_STATES - 5'h02; // [RULE10]
               2'b10: cnt <= MUL_WU_STATES - 5'h02; // [RULE10]
               2'b01: cnt <= MUL_BS_STATES - 5'h02; // [RULE10]
               2'b11: cnt <= MUL_WS_STATES - 5'h02; // [RULE10]
            endcase
         end
         else if (cnt != 5'h00)
            cnt <= cnt - 5'h01;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n)
   begin
      if (!i_reset_n)
         o_product <= 32'h00000000;
      else if (i_start)
      begin
         unique case ({i_word, i_signed})
            2'b00: o_product <= {16'h0000, 16'(i_a[7:0]) * 16'(i_b[7:0])};
            2'b01: o_product <= {16'h0000,
                      16'($signed(i_a[7:0])) * 16'($signed(i_b[7:0]))};
            2'b10: o_product <= 32'(i_a) * 32'(i_b);
            2'b11: o_product <= 32'($signed(i_a)) * 32'($signed(i_b));
         endcase
      end
   end
endmodule // cmal_mul

`default_nettype wire
